// ===== include/pcc_pkg.sv
package pcc_pkg;
   // ==========================================================
   // bus and select geometry
   localparam int ADDR_W = 8;
   localparam int IDX_W = 5;
   localparam int PAGE_W = 8;
   localparam int ALT_W = 6;
   localparam int SEL_W = PAGE_W + IDX_W;
   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_BASIC = 5'h00;
   localparam logic [IDX_W-1:0] IDX_COPPER = 5'h10;
   localparam logic [IDX_W-1:0] IDX_PAGE = 5'h16;
   localparam logic [IDX_W-1:0] IDX_ALT_PAGE = 5'h1d;
   localparam logic [IDX_W-1:0] IDX_PAGED_LO = 5'h10;
   localparam logic [IDX_W-1:0] IDX_PAGED_HI = 5'h1c;
   localparam logic [PAGE_W-1:0] COPPER_PAGE = 8'h00;
   // ==========================================================
   // basic control field positions
   localparam int BC_RESET = 15;
   localparam int BC_PD = 11;
   localparam int BC_RESTART = 9;
   // copper control field positions
   localparam int CC_ED_LO = 8;
   localparam int CC_EXT = 7;
   localparam int CC_MDI_LO = 5;
   localparam int CC_RSVD = 4;
   localparam int CC_TXDIS = 3;
   localparam int CC_ALTPD = 2;
   localparam int CC_POLDIS = 1;
   localparam int CC_JABDIS = 0;
   // ==========================================================
   // encodings and reset values
   localparam logic [1:0] ED_RX_ONLY = 2'h2;
   localparam logic [1:0] ED_NLP = 2'h3;
   localparam logic [1:0] MDI_STRAIGHT = 2'h0;
   localparam logic [1:0] MDI_CROSSED = 2'h1;
   localparam logic [1:0] MDI_AUTO = 2'h3;
   localparam logic [1:0] ED_RST = 2'h3;
   localparam logic [1:0] MDI_RST = 2'h3;
   localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
   localparam logic [PAGE_W-1:0] PAGE_UNDEF = 8'hff;
   localparam logic [ALT_W-1:0] ALT_RST = 6'h00;
   // ==========================================================
   // bus slave states
   typedef enum logic {ST_IDLE, ST_ACCESS} pcc_apb_state_type;
endpackage

// ===== include/pcc_sel_if.sv
// ==========================================================
// links the register core with its decoder and power sequencer
interface pcc_sel_if;
   logic [pcc_pkg::IDX_W-1:0] idx;
   logic [pcc_pkg::PAGE_W-1:0] page;
   logic sel_basic;
   logic sel_copper;
   logic sel_page;
   logic sel_alt;
   logic [pcc_pkg::SEL_W-1:0] sel;
   logic pd_basic;
   logic pd_alt;
   logic host_reset;
   logic host_restart;
   logic soft_reset;
   logic an_restart;
   logic power_down;
   modport dec (input idx, page, output sel_basic, sel_copper, sel_page, sel_alt, sel);
   modport seq (input pd_basic, pd_alt, host_reset, host_restart, output soft_reset, an_restart, power_down);
   modport core (output idx, page, pd_basic, pd_alt, host_reset, host_restart,
                 input sel_basic, sel_copper, sel_page, sel_alt, sel, soft_reset, an_restart, power_down);
endinterface

// ===== design/pcc_page_decode.sv
// ==========================================================
// page-aware register select, purely combinational
module pcc_page_decode (
   pcc_sel_if.dec ifc
);
   import pcc_pkg::*;

   // only 16-21 and 23-28 follow the page; 0-15, 22, 29-31 do not
   wire in_paged_range = (ifc.idx >= IDX_PAGED_LO) && (ifc.idx <= IDX_PAGED_HI) && (ifc.idx != IDX_PAGE);
   wire [PAGE_W-1:0] eff_page = in_paged_range ? ifc.page : COPPER_PAGE;

   // page on top, register number below
   assign ifc.sel = {eff_page, ifc.idx};
   assign ifc.sel_basic = (ifc.idx == IDX_BASIC);
   assign ifc.sel_page = (ifc.idx == IDX_PAGE);
   assign ifc.sel_alt = (ifc.idx == IDX_ALT_PAGE);
   assign ifc.sel_copper = (ifc.sel == {COPPER_PAGE, IDX_COPPER});
endmodule

// ===== design/pcc_pwr_seq.sv
// ==========================================================
// power-down join and the reset/restart pulses
module pcc_pwr_seq (
   input wire logic pclk,
   input wire logic presetn,
   pcc_sel_if.seq ifc
);
   import pcc_pkg::*;

   logic pwr_ff;
   logic soft_ff;
   logic anr_ff;

   // either bit alone keeps the port powered down
   wire pd_now = ifc.pd_basic | ifc.pd_alt;
   // exit happens only once both bits are clear
   wire pd_exit = pwr_ff & ~pd_now;

   // exit forces both pulses even without host request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_ff <= 1'b0;
         soft_ff <= 1'b0;
         anr_ff <= 1'b0;
      end else begin
         pwr_ff <= pd_now;
         soft_ff <= ifc.host_reset | pd_exit;
         anr_ff <= ifc.host_restart | pd_exit;
      end
   end

   assign ifc.power_down = pwr_ff;
   assign ifc.soft_reset = soft_ff;
   assign ifc.an_restart = anr_ff;

   property p_pd_exit;
      @(posedge pclk) disable iff (!presetn) $fell(pwr_ff) |-> soft_ff && anr_ff;
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down exit without reset pulses");

   property p_pd_join;
      @(posedge pclk) disable iff (!presetn) (ifc.pd_basic || ifc.pd_alt) |=> pwr_ff;
   endproperty
   a_pd_join: assert property (p_pd_join) else $error("power down not entered");
endmodule

// ===== design/pcc_copper_regs.sv
// ==========================================================
// copper control, page and alternate page registers on APB
module pcc_copper_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pcc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_10,
   input wire logic full_duplex,
   output logic ed_off,
   output logic ed_rx_only,
   output logic ed_nlp,
   output logic low_rx_thresh,
   output logic mdi_straight,
   output logic mdi_crossed,
   output logic mdi_auto,
   output logic tx_off,
   output logic power_down,
   output logic pol_force_normal,
   output logic jabber_en,
   output logic soft_reset,
   output logic an_restart,
   output logic [pcc_pkg::SEL_W-1:0] reg_select
);
   import pcc_pkg::*;

   // ==========================================================
   // state
   pcc_apb_state_type state_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [PAGE_W-1:0] page_ff;
   logic [ALT_W-1:0] alt_ff;
   logic [1:0] ed_ff;
   logic ext_ff;
   logic [1:0] mdi_ff;
   logic [1:0] mdi_act_ff;
   logic txdis_ff;
   logic altpd_ff;
   logic poldis_ff;
   logic jabdis_ff;
   logic bpd_ff;
   logic host_rst_ff;
   logic host_rs_ff;
   logic ed_off_ff;
   logic ed_rx_ff;
   logic ed_nlp_ff;
   logic lowthr_ff;
   logic mdi_st_ff;
   logic mdi_cr_ff;
   logic mdi_au_ff;
   logic txoff_ff;
   logic pol_norm_ff;
   logic jab_en_ff;
   logic [SEL_W-1:0] regsel_ff;

   pcc_sel_if ifc ();

   // ==========================================================
   // sub-blocks
   pcc_page_decode u_dec (
      .ifc (ifc)
   );

   pcc_pwr_seq u_seq (
      .pclk (pclk),
      .presetn (presetn),
      .ifc (ifc)
   );

   // ==========================================================
   // address decode
   // byte lanes below bit 2 and bit 7 fall outside the 32-word map
   wire addr_bad = (paddr[1:0] != 2'h0) || paddr[ADDR_W-1];
   wire setup = psel && !penable;
   wire commit = (state_ff == ST_ACCESS) && psel && penable && pready_ff;
   wire wr_go = commit && pwrite && !pslverr_ff;
   wire wr_basic = wr_go && ifc.sel_basic;
   wire wr_copper = wr_go && ifc.sel_copper;
   wire wr_page = wr_go && ifc.sel_page;
   wire wr_alt = wr_go && ifc.sel_alt;
   wire soft_r = ifc.soft_reset;
   wire w_ext = pwdata[CC_EXT];
   wire w_tx = pwdata[CC_TXDIS];

   assign ifc.idx = paddr[IDX_W+1:2];
   assign ifc.page = page_ff;
   assign ifc.pd_basic = bpd_ff;
   assign ifc.pd_alt = altpd_ff;
   assign ifc.host_reset = host_rst_ff;
   assign ifc.host_restart = host_rs_ff;

   // ==========================================================
   // read mux
   // self-clearing bits 15 and 9 always read back as zero
   wire [15:0] rd_basic = 16'(bpd_ff) << BC_PD;
   // reserved bit 4 and bits 15:10 read as zero
   wire [15:0] rd_copper = {6'h00, ed_ff, ext_ff, mdi_ff, 1'b0, txdis_ff, altpd_ff, poldis_ff, jabdis_ff};
   wire [15:0] rd_page = {8'h00, page_ff};
   wire [15:0] rd_alt = {10'h000, alt_ff};
   // unimplemented paged registers read as zero
   wire [15:0] rd_word = ifc.sel_basic ? rd_basic :
                         ifc.sel_copper ? rd_copper :
                         ifc.sel_page ? rd_page :
                         ifc.sel_alt ? rd_alt : 16'h0000;

   // ==========================================================
   // bus slave: answer is ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         regsel_ff <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (setup) begin
                  state_ff <= ST_ACCESS;
                  pready_ff <= 1'b1;
                  pslverr_ff <= addr_bad;
                  prdata_ff <= (pwrite || addr_bad) ? 32'h0000_0000 : {16'h0000, rd_word};
                  regsel_ff <= ifc.sel;
               end
            end
            ST_ACCESS: begin
               state_ff <= ST_IDLE;
               pready_ff <= 1'b0;
               pslverr_ff <= 1'b0;
            end
            default: begin
               state_ff <= ST_IDLE;
               pready_ff <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // page registers
   // a fresh write wins over the soft-reset effect in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_ff <= PAGE_RST;
         alt_ff <= ALT_RST;
      end else begin
         if (wr_page) begin
            page_ff <= pwdata[PAGE_W-1:0];
         end else if (soft_r && (page_ff != PAGE_RST)) begin
            page_ff <= PAGE_UNDEF;
         end
         if (wr_alt) begin
            alt_ff <= pwdata[ALT_W-1:0];
         end
      end
   end

   // ==========================================================
   // copper control and basic control storage
   // bit 4 is not stored, so a stray 1 from the host is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ed_ff <= ED_RST;
         ext_ff <= 1'b0;
         mdi_ff <= MDI_RST;
         txdis_ff <= 1'b0;
         altpd_ff <= 1'b0;
         poldis_ff <= 1'b0;
         jabdis_ff <= 1'b0;
      end else if (wr_copper) begin
         ed_ff <= pwdata[CC_ED_LO+:2];
         ext_ff <= w_ext;
         mdi_ff <= pwdata[CC_MDI_LO+:2];
         txdis_ff <= w_tx;
         altpd_ff <= pwdata[CC_ALTPD];
         poldis_ff <= pwdata[CC_POLDIS];
         jabdis_ff <= pwdata[CC_JABDIS];
      end
   end

   // host reset and restart requests are single-cycle pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bpd_ff <= 1'b0;
         host_rst_ff <= 1'b0;
         host_rs_ff <= 1'b0;
      end else begin
         if (wr_basic) begin
            bpd_ff <= pwdata[BC_PD];
         end
         host_rst_ff <= wr_basic && pwdata[BC_RESET];
         host_rs_ff <= wr_basic && pwdata[BC_RESTART];
      end
   end

   // ==========================================================
   // crossover setting is disruptive, so it is only sampled at soft reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mdi_act_ff <= MDI_RST;
      end else if (soft_r) begin
         mdi_act_ff <= mdi_ff;
      end
   end

   // ==========================================================
   // decoded controls toward the analog and link logic
   // reserved crossover code 10b drives none of the three mode outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ed_off_ff <= 1'b0;
         ed_rx_ff <= 1'b0;
         ed_nlp_ff <= 1'b1;
         lowthr_ff <= 1'b0;
         mdi_st_ff <= 1'b0;
         mdi_cr_ff <= 1'b0;
         mdi_au_ff <= 1'b1;
         txoff_ff <= 1'b0;
         pol_norm_ff <= 1'b0;
         jab_en_ff <= 1'b0;
      end else begin
         ed_off_ff <= !ed_ff[1];
         ed_rx_ff <= (ed_ff == ED_RX_ONLY);
         ed_nlp_ff <= (ed_ff == ED_NLP);
         lowthr_ff <= ext_ff;
         mdi_st_ff <= (mdi_act_ff == MDI_STRAIGHT);
         mdi_cr_ff <= (mdi_act_ff == MDI_CROSSED);
         mdi_au_ff <= (mdi_act_ff == MDI_AUTO);
         txoff_ff <= txdis_ff;
         pol_norm_ff <= poldis_ff && link_10;
         jab_en_ff <= !jabdis_ff && link_10 && !full_duplex;
      end
   end

   // ==========================================================
   // outputs
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign ed_off = ed_off_ff;
   assign ed_rx_only = ed_rx_ff;
   assign ed_nlp = ed_nlp_ff;
   assign low_rx_thresh = lowthr_ff;
   assign mdi_straight = mdi_st_ff;
   assign mdi_crossed = mdi_cr_ff;
   assign mdi_auto = mdi_au_ff;
   assign tx_off = txoff_ff;
   assign power_down = ifc.power_down;
   assign pol_force_normal = pol_norm_ff;
   assign jabber_en = jab_en_ff;
   assign soft_reset = ifc.soft_reset;
   assign an_restart = ifc.an_restart;
   assign reg_select = regsel_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ed_nlp;
      (wr_copper && pwdata[CC_ED_LO+:2] == ED_NLP) |-> ##2 ed_nlp_ff && !ed_off_ff;
   endproperty
   a_ed_nlp: assert property (p_ed_nlp) else $error("energy field 11b not decoded");

   property p_ext;
      wr_copper |-> ##2 lowthr_ff == $past(w_ext, 2);
   endproperty
   a_ext: assert property (p_ext) else $error("receive threshold does not follow bit 7");

   property p_mdi_hold;
      (wr_copper && !soft_r) ##1 (!soft_r) [*2] |-> mdi_act_ff == $past(mdi_act_ff, 2);
   endproperty
   a_mdi_hold: assert property (p_mdi_hold) else $error("crossover changed without soft reset");

   property p_mdi_apply;
      (soft_r && mdi_ff == MDI_CROSSED) |-> ##2 mdi_cr_ff && !mdi_au_ff && !mdi_st_ff;
   endproperty
   a_mdi_apply: assert property (p_mdi_apply) else $error("crossed mode not applied");

   property p_txdis;
      wr_copper |-> ##2 txoff_ff == $past(w_tx, 2);
   endproperty
   a_txdis: assert property (p_txdis) else $error("transmitter disable does not follow bit 3");

   property p_pol;
      (poldis_ff && link_10) |=> pol_norm_ff;
   endproperty
   a_pol: assert property (p_pol) else $error("polarity not forced normal");

   property p_jab;
      (jabdis_ff || full_duplex || !link_10) |=> !jab_en_ff;
   endproperty
   a_jab: assert property (p_jab) else $error("jabber active outside 10BASE-T half duplex");

   property p_page_soft;
      (soft_r && page_ff == PAGE_RST && !wr_page) |=> page_ff == PAGE_RST;
   endproperty
   a_page_soft: assert property (p_page_soft) else $error("zero page lost on soft reset");

   property p_alt_keep;
      (soft_r && !wr_alt) |=> $stable(alt_ff);
   endproperty
   a_alt_keep: assert property (p_alt_keep) else $error("alternate page changed by soft reset");
endmodule

// ===== test/pcc_host_model.sv
// ==========================================================
// management host: drives apb transfers into the register block
module pcc_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [pcc_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   import pcc_pkg::*;
   logic timed_out;
   // bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      timed_out = 1'b0;
   end
   // copper bit 4 and page bits above 7 leave the host as zero, whatever the caller passed
   function automatic logic [31:0] host_mask(input logic [ADDR_W-1:0] a);
      if (a == {1'b0, IDX_COPPER, 2'h0}) begin
         return 32'hffff_ffef;
      end
      if (a == {1'b0, IDX_PAGE, 2'h0}) begin
         return 32'h0000_00ff;
      end
      return 32'hffff_ffff;
   endfunction
   // one transfer; setup starts at the next edge, request held until pready is seen
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd & host_mask(a);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 32);
      timed_out = (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ===== test/test_phy_page_select_copper_control.sv
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t got %h exp %h", $time, g, e); end end
// ==========================================================
// register bank bench: host calls with expected values
module test_phy_page_select_copper_control;
   timeunit 1ns;
   timeprecision 1ns;
   import pcc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_10, full_duplex;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic ed_off, ed_rx_only, ed_nlp, low_rx_thresh, mdi_straight, mdi_crossed, mdi_auto;
   logic tx_off, power_down, pol_force_normal, jabber_en, soft_reset, an_restart;
   logic [SEL_W-1:0] reg_select;
   logic [PAGE_W-1:0] cur_page;
   logic [31:0] r;
   logic e;
   logic [1:0] prev;
   int num_errors = 0;
   int n_checks = 0;
   pcc_copper_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_10(link_10),
      .full_duplex(full_duplex), .ed_off(ed_off), .ed_rx_only(ed_rx_only), .ed_nlp(ed_nlp),
      .low_rx_thresh(low_rx_thresh), .mdi_straight(mdi_straight), .mdi_crossed(mdi_crossed),
      .mdi_auto(mdi_auto), .tx_off(tx_off), .power_down(power_down), .pol_force_normal(pol_force_normal),
      .jabber_en(jabber_en), .soft_reset(soft_reset), .an_restart(an_restart), .reg_select(reg_select));
   pcc_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // 20 mhz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ==========================================================
   // helpers
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // a hung bus ends the run rather than stalling it
   task automatic guard();
      if (u_host.timed_out) begin
         num_errors++;
         stop_test();
      end
   endtask
   // paged indices carry the page, all others a zero page part
   function automatic logic [SEL_W-1:0] sel_exp(input logic [IDX_W-1:0] i);
      if (i >= IDX_PAGED_LO && i <= IDX_PAGED_HI && i != IDX_PAGE) begin
         return {cur_page, i};
      end
      return {8'h00, i};
   endfunction
   function automatic logic [2:0] mdi_exp(input logic [1:0] c);
      return {c == MDI_STRAIGHT, c == MDI_CROSSED, c == MDI_AUTO};
   endfunction
   task automatic wr(input logic [IDX_W-1:0] i, input logic [15:0] d);
      u_host.xfer(1'b1, {1'b0, i, 2'h0}, {16'h0, d}, r, e);
      guard();
   endtask
   task automatic rd_chk(input logic [IDX_W-1:0] i, input logic [15:0] d);
      u_host.xfer(1'b0, {1'b0, i, 2'h0}, 32'h0, r, e);
      guard();
      `CHK(r, {16'h0, d})
      `CHK(reg_select, sel_exp(i))
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge pclk);
   endtask
   // pulses are one cycle wide, so poll every cycle with a bound
   task automatic wait_pulse();
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (soft_reset !== 1'b1 && an_restart !== 1'b1 && n < 12);
      if (soft_reset !== 1'b1 && an_restart !== 1'b1) begin
         num_errors++;
         stop_test();
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      link_10 = 1'b1;
      full_duplex = 1'b0;
      cur_page = 8'h00;
      prev = MDI_RST;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK({ed_off, ed_rx_only, ed_nlp}, 3'b001)
      `CHK({low_rx_thresh, mdi_auto, power_down}, 3'b010)
      rd_chk(IDX_COPPER, 16'h0360);
      rd_chk(IDX_PAGE, 16'h0000);
      rd_chk(IDX_ALT_PAGE, 16'h0000);
      $display("test reset finished");
      // energy field codes, each paired with the other level bits
      for (int k = 0; k < 4; k++) begin
         logic [1:0] c;
         logic [15:0] v;
         c = 2'(k);
         v = {6'h0, c, c[0], MDI_AUTO, 1'b0, c[1], 1'b0, c[0], c[1]};
         @(posedge pclk);
         link_10 <= (c != 2'h1);
         full_duplex <= (c == 2'h3);
         wr(IDX_COPPER, v);
         settle(2);
         `CHK({ed_off, ed_rx_only, ed_nlp}, {~c[1], c == ED_RX_ONLY, c == ED_NLP})
         `CHK(low_rx_thresh, c[0])
         `CHK(tx_off, c[1])
         `CHK(pol_force_normal, c == 2'h3)
         `CHK(jabber_en, c == 2'h0)
         rd_chk(IDX_COPPER, v);
      end
      $display("test copper levels finished");
      // crossover codes wait for a soft reset before they show
      for (int k = 0; k < 4; k++) begin
         logic [1:0] c;
         c = 2'(k);
         wr(IDX_COPPER, {6'h0, ED_NLP, 1'b0, c, 5'h0});
         settle(2);
         `CHK({mdi_straight, mdi_crossed, mdi_auto}, mdi_exp(prev))
         wr(IDX_BASIC, 16'h8000);
         wait_pulse();
         settle(3);
         `CHK({mdi_straight, mdi_crossed, mdi_auto}, mdi_exp(c))
         prev = c;
      end
      $display("test crossover finished");
      // paging, alternate page and soft reset on both
      wr(IDX_PAGE, 16'h0005);
      cur_page = 8'h05;
      rd_chk(IDX_COPPER, 16'h0000);
      rd_chk(IDX_PAGED_HI, 16'h0000);
      rd_chk(5'h05, 16'h0000);
      rd_chk(IDX_PAGE, 16'h0005);
      wr(IDX_ALT_PAGE, 16'h002a);
      rd_chk(5'h1e, 16'h0000);
      u_host.xfer(1'b1, 8'h5a, 32'h0000_0077, r, e);
      guard();
      `CHK(e, 1'b1)
      rd_chk(IDX_PAGE, 16'h0005);
      wr(IDX_BASIC, 16'h8000);
      wait_pulse();
      `CHK({soft_reset, an_restart}, 2'b10)
      cur_page = PAGE_UNDEF;
      rd_chk(IDX_PAGE, {8'h00, PAGE_UNDEF});
      rd_chk(IDX_ALT_PAGE, 16'h002a);
      wr(IDX_PAGE, 16'h0000);
      cur_page = 8'h00;
      wr(IDX_BASIC, 16'h8000);
      wait_pulse();
      rd_chk(IDX_PAGE, 16'h0000);
      rd_chk(IDX_COPPER, 16'h0360);
      $display("test paging finished");
      // a host restart alone pulses only the restart line
      wr(IDX_BASIC, 16'h0200);
      wait_pulse();
      `CHK({soft_reset, an_restart}, 2'b01)
      // leaving power down needs both bits clear; leaving it resets and restarts
      wr(IDX_BASIC, 16'h0800);
      settle(2);
      `CHK(power_down, 1'b1)
      wr(IDX_COPPER, 16'h0364);
      wr(IDX_BASIC, 16'h0000);
      settle(2);
      `CHK(power_down, 1'b1)
      wr(IDX_COPPER, 16'h0360);
      wait_pulse();
      `CHK({power_down, soft_reset, an_restart}, 3'b011)
      $display("test power down finished");
      // hardware reset mid-run clears both pages, unlike a soft reset
      // copper is written first, while the page still points at page 0
      wr(IDX_COPPER, 16'h0000);
      wr(IDX_PAGE, 16'h0033);
      wr(IDX_ALT_PAGE, 16'h0015);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cur_page = PAGE_RST;
      @(negedge pclk);
      `CHK({ed_nlp, mdi_auto, low_rx_thresh}, 3'b110)
      rd_chk(IDX_PAGE, 16'h0000);
      rd_chk(IDX_ALT_PAGE, 16'h0000);
      rd_chk(IDX_COPPER, 16'h0360);
      $display("test hardware reset finished");
      stop_test();
   end
endmodule
